/* common/timer_postscale_wakeup_pkg.sv */
// How it works
// R01 - Writing the postscale count stores it; a written zero counts as one.
// R02 - Reading the postscale field returns the live postscale counter.
// R03 - Postscale enable makes the postscaler count timer periods.
// R04 - Match flag sets when counted timeouts equal the programmed count.
// R05 - Interrupt source select picks postscaler match or every timeout.
// R06 - Capture enable allows recording the count; clear disables capture.
// R07 - Five-bit event select picks which interrupt source triggers capture.
// R08 - Clock select: 32 kHz, divided core, undivided fast clock, pin.
// R09 - Direction bit set counts up; reset default counts down.
// R10 - Run bit set starts the first timer; reset default is stopped.
// R11 - Periodic bit set reloads from load; reset default free-running.
// R12 - Format: binary, reserved, time of day to 23 or 255 hours.
// R13 - Prescaler codes divide by 1, 16, 256, 32768; others undefined.
// R14 - Software writes zeros to reserved control bits 22 to 20.
// R15 - Wake-up timer: 32-bit up/down counter behind a four-way prescaler.
// R16 - Wake-up prescaler has four sources; core clock chosen after reset.
// R17 - Wake-up timer keeps counting while the core clock is stopped.
// R18 - Wake-up timer reloads on overflow when periodic and at once on a load write.
// R19 - Any write to the wake-up clear register clears its interrupt.
// R20 - Wake-up load and count hold 32-bit unsigned; count is read-only.
// R21 - Wake-up count is binary or hours, minutes, seconds, 128ths of a second.
// R22 - Periodic restarts from load; free-running from maximum or minimum.
// R23 - Interrupt raised each time count reaches zero or full scale.
// R24 - Each rise of selected source copies running count to capture.
// R25 - After a postscale match its counter restarts for the next group.
// R26 - Control changes act on the next tick; reserved codes unspecified.
package timer_postscale_wakeup_pkg;
  localparam logic [31:0] FIRST_LOAD_ADDR = 32'hFFFF0320;
  localparam logic [31:0] FIRST_COUNT_ADDR = 32'hFFFF0324;
  localparam logic [31:0] FIRST_CTRL_ADDR = 32'hFFFF0328;
  localparam logic [31:0] FIRST_CLEAR_ADDR = 32'hFFFF032C;
  localparam logic [31:0] FIRST_CAPTURE_ADDR = 32'hFFFF0330;
  localparam logic [31:0] WAKE_LOAD_ADDR = 32'hFFFF0340;
  localparam logic [31:0] WAKE_COUNT_ADDR = 32'hFFFF0344;
  localparam logic [31:0] WAKE_CTRL_ADDR = 32'hFFFF0348;
  localparam logic [31:0] WAKE_CLEAR_ADDR = 32'hFFFF034C;
  localparam logic [31:0] LOAD_RESET = 32'h00000000;
  localparam logic [31:0] COUNT_RESET = 32'h0FFFFFFF;
  localparam logic [31:0] FIRST_CTRL_RESET = 32'h01000000;
  localparam logic [10:0] WAKE_CTRL_RESET = 11'h200;
  localparam logic [7:0] POST_ONE = 8'h01;
  localparam logic [1:0] SRC_OSC = 2'h0;
  localparam logic [1:0] SRC_CORE_DIV = 2'h1;
  localparam logic [1:0] SRC_FAST = 2'h2;
  localparam logic [1:0] SRC_PIN = 2'h3;
  localparam logic [1:0] WAKE_SRC_XTAL = 2'h2;
  localparam logic [1:0] WAKE_SRC_FAST = 2'h3;
  localparam logic [3:0] SCALE_16 = 4'h4;
  localparam logic [3:0] SCALE_256 = 4'h8;
  localparam logic [3:0] SCALE_32K = 4'hF;
  localparam logic [14:0] MASK_1 = 15'h0000;
  localparam logic [14:0] MASK_16 = 15'h000F;
  localparam logic [14:0] MASK_256 = 15'h00FF;
  localparam logic [14:0] MASK_32K = 15'h7FFF;
  localparam logic [1:0] FMT_TOD23 = 2'h2;
  localparam logic [1:0] FMT_TOD255 = 2'h3;
  localparam logic [7:0] HOURS_23 = 8'h17;
  localparam logic [7:0] HOURS_255 = 8'hFF;
  localparam logic [5:0] SIXTY_MAX = 6'h3B;
  localparam logic [6:0] FRAC_MAX = 7'h7F;
  localparam logic [31:0] BIN_FULL = 32'hFFFFFFFF;
  localparam logic [7:0] DIV_ONE = 8'h01;

  typedef struct packed {
    logic [1:0] clock_select;
    logic count_up_select;
    logic run;
    logic periodic_select;
    logic [1:0] count_format;
    logic [3:0] prescale_select;
  } tcfg_t;

  typedef struct packed {
    logic [7:0] postscale_count_field;
    logic postscale_enable;
    logic [2:0] rsv_hi;
    logic postscale_match_flag;
    logic irq_source_select;
    logic capture_enable;
    logic [4:0] capture_event_select;
    logic rsv_lo;
    tcfg_t base;
  } first_ctrl_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;
endpackage

/* rtl/timer_postscale_wakeup.sv */
// The plain strobed port was decided locally.
`timescale 1ns/100ps

module timer_count_core
  import timer_postscale_wakeup_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic src_tick,
  input wire tcfg_t cfg,
  input wire logic [31:0] load,
  input wire logic load_now,
  output logic [31:0] count_q,
  output logic timeout_q
);
  logic [14:0] pre_q;
  logic [14:0] mask;
  logic pre_tick;
  logic tod;
  logic [7:0] hmax;
  logic [31:0] full;
  logic at_end;
  logic [31:0] restart;
  logic [31:0] step;

  function automatic logic [31:0] tod_step(input logic [31:0] c, input logic up,
                                           input logic [7:0] hm);
    logic [7:0] h;
    logic [5:0] m;
    logic [5:0] s;
    logic [6:0] f;
    h = c[31:24];
    m = c[21:16];
    s = c[13:8];
    f = c[6:0];
    if (up) begin
      if (f != FRAC_MAX) begin
        f = f + 7'h01;
      end else begin
        f = '0;
        if (s != SIXTY_MAX) begin
          s = s + 6'h01;
        end else begin
          s = '0;
          if (m != SIXTY_MAX) begin
            m = m + 6'h01;
          end else begin
            m = '0;
            h = (h == hm) ? 8'h00 : h + 8'h01;
          end
        end
      end
    end else begin
      if (f != 7'h00) begin
        f = f - 7'h01;
      end else begin
        f = FRAC_MAX;
        if (s != 6'h00) begin
          s = s - 6'h01;
        end else begin
          s = SIXTY_MAX;
          if (m != 6'h00) begin
            m = m - 6'h01;
          end else begin
            m = SIXTY_MAX;
            h = (h == 8'h00) ? hm : h - 8'h01;
          end
        end
      end
    end
    return {h, 2'h0, m, 2'h0, s, 1'h0, f};
  endfunction

  always_comb begin
    case (cfg.prescale_select)
      SCALE_16: mask = MASK_16;
      SCALE_256: mask = MASK_256;
      SCALE_32K: mask = MASK_32K;
      default: mask = MASK_1;
    endcase
  end

  // Reserved prescale and format codes fall back to divide by one and binary
  assign pre_tick = cfg.run && src_tick && ((pre_q & mask) == mask); // see R13 see R26
  assign tod = cfg.count_format[1]; // see R12 see R21
  assign hmax = (cfg.count_format == FMT_TOD23) ? HOURS_23 : HOURS_255;
  assign full = tod ? {hmax, 2'h0, SIXTY_MAX, 2'h0, SIXTY_MAX, 1'h0, FRAC_MAX} : BIN_FULL;
  assign at_end = cfg.count_up_select ? (count_q == full) : (count_q == 32'h00000000); // see R09
  assign restart = cfg.periodic_select ? load
                 : (cfg.count_up_select ? 32'h00000000 : full); // see R11 see R22
  assign step = tod ? tod_step(count_q, cfg.count_up_select, hmax)
              : (cfg.count_up_select ? count_q + 32'h00000001 : count_q - 32'h00000001);

  always_ff @(posedge clk) begin
    if (reset || !cfg.run) begin
      pre_q <= '0;
    end else if (src_tick) begin
      pre_q <= pre_q + 15'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      count_q <= COUNT_RESET;
    end else if (load_now) begin
      count_q <= load; // see R18
    end else if (pre_tick) begin
      count_q <= at_end ? restart : step; // see R22
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      timeout_q <= 1'b0;
    end else begin
      timeout_q <= pre_tick && at_end && !load_now; // see R23
    end
  end
endmodule

module timer_postscale_wakeup
  import timer_postscale_wakeup_pkg::*;
#(
  parameter int unsigned EVENT_N = 18
) (
  input wire logic clk,
  input wire logic reset,
  input wire bus_req_t bus,
  input wire logic osc_32k,
  input wire logic external_count_pin,
  input wire logic watch_crystal,
  input wire logic [2:0] core_clock_divider,
  input wire logic core_clock_stopped,
  input wire logic [EVENT_N-1:0] irq_sources,
  output logic [31:0] rdata,
  output logic first_timer_irq,
  output logic wakeup_timer_irq
);
  logic [2:0] pin_meta_q;
  logic [2:0] pin_sync_q;
  logic [2:0] pin_prev_q;
  logic [2:0] pin_rise;
  logic [6:0] div_q;
  logic [6:0] div_mask;
  logic core_tick;
  logic first_src;
  logic wake_src;
  first_ctrl_t first_ctrl_q;
  first_ctrl_t first_ctrl_d;
  tcfg_t wake_cfg_q;
  logic [31:0] first_load_q;
  logic [31:0] wake_load_q;
  logic [31:0] wake_load_in;
  logic [31:0] capture_q;
  logic [7:0] post_count_q;
  logic match_q;
  logic [EVENT_N-1:0] irq_prev_q;
  logic [31:0] rise_wide;
  logic cap_hit;
  logic post_hit;
  logic first_irq_evt;
  logic [31:0] first_count;
  logic [31:0] wake_count;
  logic first_timeout;
  logic wake_timeout;
  logic wr_first_load;
  logic wr_first_ctrl;
  logic wr_first_clear;
  logic wr_wake_load;
  logic wr_wake_ctrl;
  logic wr_wake_clear;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Pin inputs: osc, external count pin, watch crystal
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
      pin_prev_q <= '0;
    end else begin
      pin_meta_q <= {watch_crystal, external_count_pin, osc_32k};
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  assign pin_rise = pin_sync_q & ~pin_prev_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 7'h01;
    end
  end

  assign div_mask = 7'((DIV_ONE << core_clock_divider) - DIV_ONE);
  assign core_tick = (div_q & div_mask) == div_mask;

  // Core-derived sources stall the first timer while the core clock is stopped
  always_comb begin
    case (first_ctrl_q.base.clock_select) // see R08
      SRC_OSC: first_src = pin_rise[0];
      SRC_CORE_DIV: first_src = core_tick && !core_clock_stopped;
      SRC_FAST: first_src = !core_clock_stopped;
      default: first_src = pin_rise[1];
    endcase
  end

  // The wake-up path ignores the core stop so it can time low-power states
  always_comb begin
    case (wake_cfg_q.clock_select) // see R16 see R17
      SRC_OSC: wake_src = pin_rise[0];
      SRC_CORE_DIV: wake_src = core_tick;
      WAKE_SRC_XTAL: wake_src = pin_rise[2];
      default: wake_src = 1'b1;
    endcase
  end

  assign wr_first_load = bus.wr && (bus.addr == FIRST_LOAD_ADDR);
  assign wr_first_ctrl = bus.wr && (bus.addr == FIRST_CTRL_ADDR);
  assign wr_first_clear = bus.wr && (bus.addr == FIRST_CLEAR_ADDR);
  assign wr_wake_load = bus.wr && (bus.addr == WAKE_LOAD_ADDR);
  assign wr_wake_ctrl = bus.wr && (bus.addr == WAKE_CTRL_ADDR);
  assign wr_wake_clear = bus.wr && (bus.addr == WAKE_CLEAR_ADDR);

  always_comb begin
    first_ctrl_d = first_ctrl_t'(bus.wdata);
    if (first_ctrl_d.postscale_count_field == 8'h00) begin
      first_ctrl_d.postscale_count_field = POST_ONE; // see R01
    end
    first_ctrl_d.rsv_hi = '0; // see R14
    first_ctrl_d.postscale_match_flag = 1'b0;
    first_ctrl_d.rsv_lo = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      first_ctrl_q <= first_ctrl_t'(FIRST_CTRL_RESET); // see R09 see R10 see R11
    end else if (wr_first_ctrl) begin
      first_ctrl_q <= first_ctrl_d; // see R01
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wake_cfg_q <= tcfg_t'(WAKE_CTRL_RESET); // see R16
    end else if (wr_wake_ctrl) begin
      wake_cfg_q <= tcfg_t'(bus.wdata[10:0]);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      first_load_q <= LOAD_RESET;
      wake_load_q <= LOAD_RESET;
    end else begin
      if (wr_first_load) begin
        first_load_q <= bus.wdata;
      end
      if (wr_wake_load) begin
        wake_load_q <= bus.wdata; // see R20
      end
    end
  end

  // A load write reaches the wake-up counter in the same edge as the register
  assign wake_load_in = wr_wake_load ? bus.wdata : wake_load_q;

  timer_count_core first_core (
    .clk(clk),
    .reset(reset),
    .src_tick(first_src),
    .cfg(first_ctrl_q.base),
    .load(first_load_q),
    .load_now(wr_first_ctrl && first_ctrl_d.base.run && !first_ctrl_q.base.run), // see R10
    .count_q(first_count),
    .timeout_q(first_timeout)
  );

  timer_count_core wake_core (
    .clk(clk),
    .reset(reset),
    .src_tick(wake_src),
    .cfg(wake_cfg_q),
    .load(wake_load_in),
    .load_now(wr_wake_load), // see R18
    .count_q(wake_count), // see R15 see R21
    .timeout_q(wake_timeout)
  );

  assign post_hit = first_timeout && first_ctrl_q.postscale_enable
                  && (post_count_q + 8'h01 == first_ctrl_q.postscale_count_field); // see R04

  // A control write restarts the current group of timeouts
  always_ff @(posedge clk) begin
    if (reset || wr_first_ctrl) begin
      post_count_q <= '0;
    end else if (first_timeout && first_ctrl_q.postscale_enable) begin
      post_count_q <= post_hit ? 8'h00 : post_count_q + 8'h01; // see R03 see R25
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      match_q <= 1'b0;
    end else if (post_hit) begin
      match_q <= 1'b1; // see R04
    end else if (wr_first_clear) begin
      match_q <= 1'b0;
    end
  end

  assign first_irq_evt = first_ctrl_q.irq_source_select ? post_hit : first_timeout; // see R05

  always_ff @(posedge clk) begin
    if (reset) begin
      first_timer_irq <= 1'b0;
      wakeup_timer_irq <= 1'b0;
    end else begin
      if (first_irq_evt) begin
        first_timer_irq <= 1'b1; // see R23
      end else if (wr_first_clear) begin
        first_timer_irq <= 1'b0;
      end
      if (wake_timeout) begin
        wakeup_timer_irq <= 1'b1;
      end else if (wr_wake_clear) begin
        wakeup_timer_irq <= 1'b0; // see R19
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq_prev_q <= '0;
    end else begin
      irq_prev_q <= irq_sources;
    end
  end

  assign rise_wide = 32'(irq_sources & ~irq_prev_q);
  assign cap_hit = first_ctrl_q.capture_enable
                 && rise_wide[first_ctrl_q.capture_event_select]; // see R06 see R07

  always_ff @(posedge clk) begin
    if (reset) begin
      capture_q <= LOAD_RESET;
    end else if (cap_hit) begin
      capture_q <= first_count; // see R24
    end
  end

  // Read data stands only in the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (reset || !bus.rd) begin
      rdata <= '0;
    end else begin
      case (bus.addr)
        FIRST_LOAD_ADDR: rdata <= first_load_q;
        FIRST_COUNT_ADDR: rdata <= first_count;
        FIRST_CTRL_ADDR: rdata <= {post_count_q, first_ctrl_q[23:20], match_q,
                                   first_ctrl_q[18:0]}; // see R02 see R04
        FIRST_CAPTURE_ADDR: rdata <= capture_q;
        WAKE_LOAD_ADDR: rdata <= wake_load_q;
        WAKE_COUNT_ADDR: rdata <= wake_count; // see R20
        WAKE_CTRL_ADDR: rdata <= {21'h000000, wake_cfg_q};
        default: rdata <= '0;
      endcase
    end
  end

  sequence s_wake_write;
    wr_wake_load;
  endsequence

  sequence s_first_stopped;
    !first_ctrl_q.base.run [*2];
  endsequence

  a_post_zero_one: // see R01
    assert property (wr_first_ctrl && bus.wdata[31:24] == 8'h00
                     |=> first_ctrl_q.postscale_count_field == POST_ONE)
    else $error("postscale zero not stored as one");

  a_post_live_read: // see R02
    assert property (bus.rd && bus.addr == FIRST_CTRL_ADDR
                     |=> rdata[31:24] == $past(post_count_q))
    else $error("postscale read is not the live count");

  a_post_group_restart: // see R25
    assert property (post_hit && !wr_first_ctrl |=> post_count_q == 8'h00)
    else $error("postscale counter did not restart");

  a_match_flag_set: // see R04
    assert property (post_hit |=> match_q && (first_timer_irq || !first_ctrl_q.irq_source_select))
    else $error("match flag or postscale interrupt missing");

  a_timeout_irq_path: // see R05
    assert property (first_timeout && !first_ctrl_q.irq_source_select |=> first_timer_irq)
    else $error("timeout did not raise interrupt");

  a_capture_copy: // see R24
    assert property (cap_hit |=> capture_q == $past(first_count))
    else $error("capture missed the running count");

  a_capture_off: // see R06
    assert property (!first_ctrl_q.capture_enable |=> capture_q == $past(capture_q))
    else $error("capture changed while disabled");

  a_wake_load_now: // see R18
    assert property (s_wake_write |=> wake_count == $past(bus.wdata))
    else $error("wake-up load write did not reload");

  a_wake_clear_irq: // see R19
    assert property (wr_wake_clear && !wake_timeout |=> !wakeup_timer_irq)
    else $error("wake-up clear did not clear interrupt");

  a_first_stop_hold: // see R10
    assert property (s_first_stopped |-> $stable(first_count))
    else $error("stopped timer changed its count");
endmodule

/* sim/timer_postscale_wakeup_bench.sv */
`timescale 1ns/100ps

`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin fail_count++; $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module timer_postscale_wakeup_bench;
  import timer_postscale_wakeup_pkg::*;

  logic clk;
  logic reset;
  bus_req_t bus;
  logic [1:0] tog_q;
  logic [2:0] core_clock_divider;
  logic core_clock_stopped;
  logic [17:0] irq_sources;
  logic [31:0] rdata;
  logic first_timer_irq;
  logic wakeup_timer_irq;
  int fail_count;
  int num_checks;
  logic [31:0] d;
  logic [31:0] d2;

  timer_postscale_wakeup #(.EVENT_N(18)) dut_u (
    .clk(clk),
    .reset(reset),
    .bus(bus),
    .osc_32k(tog_q[1]),
    .external_count_pin(tog_q[1]),
    .watch_crystal(tog_q[1]),
    .core_clock_divider(core_clock_divider),
    .core_clock_stopped(core_clock_stopped),
    .irq_sources(irq_sources),
    .rdata(rdata),
    .first_timer_irq(first_timer_irq),
    .wakeup_timer_irq(wakeup_timer_irq)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Slow external sources: one rising edge every four clocks
  always @(posedge clk) begin
    tog_q <= reset ? 2'h0 : tog_q + 2'h1;
  end

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '{addr: a, wdata: v, wr: 1'b0, rd: 1'b0};
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b0};
    #1 v = rdata;
  endtask

  // Interrupt must stay low for lo cycles and be up by hi cycles
  task automatic wait_irq(input int sel, input int lo, input int hi);
    int n;
    logic v;
    n = 0;
    v = 1'b0;
    while (v !== 1'b1 && n < hi) begin
      @(posedge clk);
      #1 v = (sel == 0) ? first_timer_irq : wakeup_timer_irq;
      n++;
    end
    if (v !== 1'b1) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, v, 1'b1);
      give_verdict();
    end else begin
      `CHK(n > lo, 1'b1);
    end
  endtask

  // Stop a timer, let pending timeouts land, then clear its interrupt
  task automatic stop_clear(input int sel);
    wr((sel == 0) ? FIRST_CTRL_ADDR : WAKE_CTRL_ADDR, 32'h0);
    repeat (4) @(posedge clk);
    wr((sel == 0) ? FIRST_CLEAR_ADDR : WAKE_CLEAR_ADDR, 32'hA5);
    @(posedge clk);
    #1;
    `CHK((sel == 0) ? first_timer_irq : wakeup_timer_irq, 1'b0);
  endtask

  task automatic pulse(input int idx);
    @(posedge clk);
    irq_sources <= 18'h00001 << idx;
    repeat (2) @(posedge clk);
    irq_sources <= 18'h0;
    repeat (2) @(posedge clk);
  endtask

  initial begin
    reset = 1'b1;
    bus = '0;
    core_clock_divider = 3'h2;
    core_clock_stopped = 1'b0;
    irq_sources = 18'h0;
    fail_count = 0;
    num_checks = 0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;

    rd(WAKE_COUNT_ADDR, d);
    `CHK(d, COUNT_RESET);
    rd(WAKE_LOAD_ADDR, d);
    `CHK(d, LOAD_RESET);
    rd(FIRST_CTRL_ADDR, d);
    `CHK(d, {8'h00, FIRST_CTRL_RESET[23:0]});
    rd(32'hFFFF0338, d);
    `CHK(d, 32'h0);
    rd(WAKE_CLEAR_ADDR, d);
    `CHK(d, 32'h0);

    // Load write reloads at once; the count register ignores writes
    wr(WAKE_LOAD_ADDR, 32'h12345678);
    rd(WAKE_COUNT_ADDR, d);
    `CHK(d, 32'h12345678);
    wr(WAKE_COUNT_ADDR, 32'h0);
    rd(WAKE_COUNT_ADDR, d);
    `CHK(d, 32'h12345678);

    // Wake-up: fast clock, down, periodic from 3
    wr(WAKE_LOAD_ADDR, 32'h3);
    wr(WAKE_CTRL_ADDR, 32'h6C0);
    wait_irq(1, 0, 12);
    rd(WAKE_COUNT_ADDR, d);
    `CHK(d <= 32'h3, 1'b1);
    @(posedge clk) core_clock_stopped <= 1'b1;
    rd(WAKE_COUNT_ADDR, d);
    rd(WAKE_COUNT_ADDR, d2);
    `CHK(d !== d2, 1'b1);
    @(posedge clk) core_clock_stopped <= 1'b0;
    stop_clear(1);

    // Wake-up counting up toward full scale
    wr(WAKE_LOAD_ADDR, 32'hFFFFFFFC);
    wr(WAKE_CTRL_ADDR, 32'h7C0);
    rd(WAKE_COUNT_ADDR, d);
    `CHK(d >= 32'hFFFFFFFC, 1'b1);
    wait_irq(1, 0, 12);
    stop_clear(1);

    // Time-of-day up: two ticks carry the fraction into the seconds
    wr(WAKE_LOAD_ADDR, 32'h0000007E);
    wr(WAKE_CTRL_ADDR, 32'h7A0);
    wr(WAKE_CTRL_ADDR, 32'h0);
    rd(WAKE_COUNT_ADDR, d);
    `CHK(d, 32'h00000100);

    // Prescaler: timeout every four prescaled ticks
    for (int i = 0; i < 2; i++) begin
      wr(WAKE_LOAD_ADDR, 32'h3);
      wr(WAKE_CTRL_ADDR, 32'h6C0 | ((i == 0) ? {28'h0, SCALE_16} : {28'h0, SCALE_256}));
      wait_irq(1, (i == 0) ? 32 : 512, (i == 0) ? 100 : 1300);
      stop_clear(1);
    end
    // Largest prescaler: load zero times out on the first prescaled tick
    wr(WAKE_LOAD_ADDR, 32'h0);
    wr(WAKE_CTRL_ADDR, 32'h6C0 | {28'h0, SCALE_32K});
    wait_irq(1, 32000, 33000);
    stop_clear(1);

    // Every first-timer clock source makes timeouts
    for (int s = 0; s < 4; s++) begin
      wr(FIRST_LOAD_ADDR, 32'h2);
      wr(FIRST_CTRL_ADDR, 32'hC0 | (s << 9));
      wait_irq(0, 0, 60);
      stop_clear(0);
    end
    rd(FIRST_COUNT_ADDR, d);
    rd(FIRST_COUNT_ADDR, d2);
    `CHK(d2, d);

    // Postscaler counts three timeouts before the interrupt
    wr(FIRST_LOAD_ADDR, 32'h2);
    wr(FIRST_CTRL_ADDR, 32'h038404C0);
    wait_irq(0, 8, 30);
    rd(FIRST_CTRL_ADDR, d);
    `CHK(d[19], 1'b1);
    `CHK(d[31:24] < 8'h03, 1'b1);
    stop_clear(0);
    wr(FIRST_CTRL_ADDR, 32'h008404C0);
    wait_irq(0, 0, 10);
    stop_clear(0);
    wr(FIRST_CTRL_ADDR, 32'h038004C0);
    wait_irq(0, 0, 10);
    stop_clear(0);

    // Capture: disabled, wrong source, then the selected source
    wr(FIRST_LOAD_ADDR, 32'hFFFFFFF0);
    wr(FIRST_CTRL_ADDR, 32'h000055C0);
    pulse(5);
    rd(FIRST_CAPTURE_ADDR, d);
    `CHK(d, 32'h0);
    wr(FIRST_CTRL_ADDR, 32'h000255C0);
    pulse(6);
    rd(FIRST_CAPTURE_ADDR, d);
    `CHK(d, 32'h0);
    pulse(5);
    rd(FIRST_CAPTURE_ADDR, d);
    `CHK(d >= 32'hFFFFFFF0, 1'b1);
    stop_clear(0);

    give_verdict();
  end
endmodule
